// ### verilog/cia_top.sv
/*
  cia_top: group 0/1 acknowledge registers and group 0 enable register of the
  processor-side interrupt controller interface, with their access checks.
  assumes: the prioritisation logic presents the highest-priority pending
  interrupt, its group and whether it is signalable; it takes ack pulses.
*/
`timescale 1ns/1ps
module cia_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire cia_pkg::cia_req_t req,
  input wire cia_pkg::cia_ctl_t ctl,
  input wire logic [23:0] hppi_id,
  input wire logic hppi_valid,
  input wire logic hppi_grp0,
  input wire logic hppi_signalable,
  input wire logic hppi_ackable,
  input wire logic hppi_secure_only,
  input wire logic hppi_one_of_n,
  output cia_pkg::cia_rsp_t rsp,
  output logic ack_pulse,
  output logic [23:0] ack_id,
  output logic retarget_pulse,
  output logic group0_enable,
  output logic virt_group0_enable,
  output logic virt_access
);
  import cia_pkg::*;

  typedef enum logic [2:0] {
    CIA_ST_IDLE = 3'b001,
    CIA_ST_SYNC = 3'b010,
    CIA_ST_RESP = 3'b100
  } cia_state_t;

  typedef struct packed {
    cia_state_t st;
    logic [1:0] cnt;
    cia_rsp_t rsp;
    logic ack;
    logic [23:0] ack_id;
    logic retarget;
    logic virt;
  } cia_top_state_t;

  cia_top_state_t s_q;
  cia_top_state_t s_d;

  // one decoder for all three registers
  function automatic logic sel(input cia_req_t r, input logic [3:0] crm,
                               input logic [2:0] op2);
    sel = r.valid && r.op0 == CIA_OP0 && r.op1 == CIA_OP1 && r.crn == CIA_CRN &&
          r.crm == crm && r.op2 == op2;
  endfunction : sel

  logic hit_ack0;
  logic hit_ack1;
  logic hit_en0;
  logic is_grp0;
  cia_res_t chk_res;
  cia_lvl_t chk_lvl;
  logic phys_we;
  logic virt_we;
  logic phys_en;
  logic virt_en;
  logic [23:0] id_mask;
  logic [23:0] ack_value;
  logic grp_match;

  assign hit_ack0 = sel(req, CIA_CRM_ACK0, CIA_OP2_ACK0) & ~req.write;
  assign hit_ack1 = sel(req, CIA_CRM_GRP, CIA_OP2_ACK1) & ~req.write;
  assign hit_en0 = sel(req, CIA_CRM_GRP, CIA_OP2_EN0);
  assign is_grp0 = hit_ack0 | hit_en0;

  cia_check u_check (
    .level(req.level),
    .grp0(is_grp0),
    .write(req.write),
    .fine_applies(hit_en0),
    .ctl(ctl),
    .result(chk_res),
    .trap_level(chk_lvl)
  );

  // enable register writes only when the checks allow them
  assign phys_we = hit_en0 & req.write & (chk_res == CIA_RES_DIRECT) & (s_q.st == CIA_ST_IDLE);
  assign virt_we = hit_en0 & req.write & (chk_res == CIA_RES_VIRT) & (s_q.st == CIA_ST_IDLE);

  cia_enable_store u_en (
    .core_clk(core_clk),
    .rstn(rstn),
    .phys_we(phys_we),
    .virt_we(virt_we),
    .wbit(req.wdata[CIA_EN_BIT]),
    .phys_en(phys_en),
    .virt_en(virt_en)
  );

  // narrow identifiers read zero in bits 23:16
  assign id_mask = ctl.id_wide ? 24'hffffff : 24'h00ffff;

  // acknowledgeable only for the right group, enabled (group 0 only), and high enough
  assign grp_match = hit_ack0 ? (hppi_grp0 & phys_en) : ~hppi_grp0;
  always_comb begin
    if (!hppi_valid || !hppi_signalable) begin
      ack_value = CIA_ID_NONE;
    end else if (grp_match && hppi_ackable) begin
      ack_value = hppi_id & id_mask;
    end else if (hppi_secure_only) begin
      ack_value = CIA_ID_SECURE;
    end else if (!hppi_grp0 && hit_ack0) begin
      ack_value = CIA_ID_NONSEC;
    end else begin
      ack_value = CIA_ID_NONE;
    end
  end

  // access sequencer: acks hold back the answer while the core is masked
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.retarget = 1'b0;
    s_d.rsp.done = 1'b0;
    s_d.virt = 1'b0;
    case (s_q.st)
      CIA_ST_IDLE: begin
        if (hit_ack0 || hit_ack1 || hit_en0) begin
          s_d.rsp.result = chk_res;
          s_d.rsp.trap_level = chk_lvl;
          s_d.rsp.ec = (chk_res == CIA_RES_TRAP) ? CIA_EC_SYSREG : 6'h00;
          s_d.rsp.rdata = 64'h0;
          s_d.virt = (chk_res == CIA_RES_VIRT);
          if (chk_res == CIA_RES_DIRECT && hit_en0) begin
            s_d.rsp.rdata = {63'h0, phys_en};
          end
          if (chk_res == CIA_RES_DIRECT && (hit_ack0 || hit_ack1)) begin
            s_d.rsp.rdata = {40'h0, ack_value};
            s_d.ack = (ack_value == (hppi_id & id_mask)) && grp_match && hppi_ackable &&
                      hppi_valid && hppi_signalable;
            s_d.ack_id = hppi_id & id_mask;
          end
          // enable falling while a 1-of-N group 0 interrupt is ours
          if (phys_we && phys_en && !req.wdata[CIA_EN_BIT] && hppi_valid && hppi_grp0 &&
              hppi_one_of_n) begin
            s_d.retarget = 1'b1;
          end
          if ((hit_ack0 || hit_ack1) && chk_res == CIA_RES_DIRECT && ctl.core_masked) begin
            s_d.st = CIA_ST_SYNC;
            s_d.cnt = CIA_SYNC_CYCLES;
          end else begin
            s_d.rsp.done = 1'b1;
          end
        end
      end
      CIA_ST_SYNC: begin
        // activation must reach exception signalling before the core resumes
        if (s_q.cnt == 2'h1) begin
          s_d.st = CIA_ST_RESP;
        end
        s_d.cnt = s_q.cnt - 2'h1;
      end
      CIA_ST_RESP: begin
        s_d.rsp.done = 1'b1;
        s_d.st = CIA_ST_IDLE;
      end
      default: begin
        s_d.st = CIA_ST_IDLE;
      end
    endcase
  end

  // sequencer state registered here (the enables are held in cia_enable_store); reset values are constants
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: CIA_ST_IDLE, cnt: 2'h0, rsp: '0, ack: 1'b0, ack_id: 24'h0,
               retarget: 1'b0, virt: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.rsp;
  assign ack_pulse = s_q.ack;
  assign ack_id = s_q.ack_id;
  assign retarget_pulse = s_q.retarget;
  assign group0_enable = phys_en;
  assign virt_group0_enable = virt_en;
  assign virt_access = s_q.virt;

endmodule : cia_top

// ### verilog/cia_pkg.sv
/*
  cia_pkg: shared constants and carrier types for the acknowledge / group 0
  enable block of the processor-side interrupt controller interface.
  assumes: one core clock, asynchronous active-low warm reset.
*/
package cia_pkg;

  // system register encoding
  localparam logic [1:0] CIA_OP0 = 2'h3;
  localparam logic [2:0] CIA_OP1 = 3'h0;
  localparam logic [3:0] CIA_CRN = 4'hc;
  localparam logic [3:0] CIA_CRM_ACK0 = 4'h8;
  localparam logic [2:0] CIA_OP2_ACK0 = 3'h0;
  localparam logic [3:0] CIA_CRM_GRP = 4'hc;
  localparam logic [2:0] CIA_OP2_ACK1 = 3'h0;
  localparam logic [2:0] CIA_OP2_EN0 = 3'h6;

  // exception class for system register access traps
  localparam logic [5:0] CIA_EC_SYSREG = 6'h18;

  // special identifiers
  localparam logic [23:0] CIA_ID_SECURE = 24'h0003fc;
  localparam logic [23:0] CIA_ID_NONSEC = 24'h0003fd;
  localparam logic [23:0] CIA_ID_NONE = 24'h0003ff;

  // identifier field layout
  localparam int CIA_ID_W = 24;
  localparam int CIA_ID_NARROW_W = 16;

  // group 0 enable field and reset value
  localparam int CIA_EN_BIT = 0;
  localparam logic CIA_EN_RESET = 1'b0;

  // number of stages of the self-synchronising acknowledge path
  localparam logic [1:0] CIA_SYNC_CYCLES = 2'h2;

  // privilege levels
  typedef enum logic [1:0] {
    CIA_LVL0 = 2'h0,
    CIA_LVL1 = 2'h1,
    CIA_LVL2 = 2'h2,
    CIA_LVL3 = 2'h3
  } cia_lvl_t;

  // outcome of the access checks
  typedef enum logic [2:0] {
    CIA_RES_DIRECT = 3'h0,
    CIA_RES_UNDEF = 3'h1,
    CIA_RES_TRAP = 3'h2,
    CIA_RES_VIRT = 3'h3,
    CIA_RES_NONE = 3'h4
  } cia_res_t;

  // one system register access from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    cia_lvl_t level;
    logic [63:0] wdata;
  } cia_req_t;

  // control bits held by other system registers
  typedef struct packed {
    logic lvl3_present;
    logic lvl2_enabled;
    logic sre_lvl1;
    logic sre_lvl2;
    logic sre_lvl3;
    logic trap_all_group0;
    logic fast_irq_route_to_hyp;
    logic fiq_to_lvl3;
    logic fine_trap_feature;
    logic fine_trap_allow;
    logic fine_read_trap_grpen;
    logic fine_write_trap_grpen;
    logic sdd_undef_priority;
    logic sdd_undef;
    logic irq_to_lvl3;
    logic trap_all_group1;
    logic irq_route_to_hyp;
    logic core_masked;
    logic id_wide;
  } cia_ctl_t;

  // answer to the core
  typedef struct packed {
    logic done;
    cia_res_t result;
    cia_lvl_t trap_level;
    logic [5:0] ec;
    logic [63:0] rdata;
  } cia_rsp_t;

endpackage : cia_pkg

// ### verilog/cia_check.sv
/*
  cia_check: combinational access checker for one system register access.
  assumes: the request and control bits are stable in the cycle they are seen.
*/
`timescale 1ns/1ps
module cia_check (
  input wire cia_pkg::cia_lvl_t level,
  input wire logic grp0,
  input wire logic write,
  input wire logic fine_applies,
  input wire cia_pkg::cia_ctl_t ctl,
  output cia_pkg::cia_res_t result,
  output cia_pkg::cia_lvl_t trap_level
);
  import cia_pkg::*;

  logic route3;
  logic tall;
  logic hyp_route;
  logic fine_hit;

  // group 0 uses the fast-interrupt controls, group 1 the normal ones
  assign route3 = ctl.lvl3_present & (grp0 ? ctl.fiq_to_lvl3 : ctl.irq_to_lvl3);
  assign tall = grp0 ? ctl.trap_all_group0 : ctl.trap_all_group1;
  assign hyp_route = grp0 ? ctl.fast_irq_route_to_hyp : ctl.irq_route_to_hyp;
  assign fine_hit = fine_applies & ctl.lvl2_enabled & ctl.fine_trap_feature &
                    (~ctl.lvl3_present | ctl.fine_trap_allow) &
                    (write ? ctl.fine_write_trap_grpen : ctl.fine_read_trap_grpen);

  // priority chain, first match wins
  always_comb begin
    result = CIA_RES_DIRECT;
    trap_level = level;
    case (level)
      CIA_LVL0: begin
        result = CIA_RES_UNDEF;
      end
      CIA_LVL1, CIA_LVL2: begin
        if (route3 && ctl.sdd_undef_priority) begin
          result = CIA_RES_UNDEF;
        end else if (!(level == CIA_LVL1 ? ctl.sre_lvl1 : ctl.sre_lvl2)) begin
          result = CIA_RES_TRAP;
          trap_level = level;
        end else if (level == CIA_LVL1 && fine_hit) begin
          result = CIA_RES_TRAP;
          trap_level = CIA_LVL2;
        end else if (level == CIA_LVL1 && ctl.lvl2_enabled && tall) begin
          result = CIA_RES_TRAP;
          trap_level = CIA_LVL2;
        end else if (level == CIA_LVL1 && ctl.lvl2_enabled && hyp_route) begin
          result = CIA_RES_VIRT;
        end else if (route3) begin
          result = ctl.sdd_undef ? CIA_RES_UNDEF : CIA_RES_TRAP;
          trap_level = CIA_LVL3;
        end
      end
      CIA_LVL3: begin
        if (!ctl.sre_lvl3) begin
          result = CIA_RES_TRAP;
          trap_level = CIA_LVL3;
        end
      end
      default: begin
        result = CIA_RES_UNDEF;
      end
    endcase
  end

endmodule : cia_check

// ### verilog/cia_enable_store.sv
/*
  cia_enable_store: holds the physical and virtual group 0 enable bits.
  assumes: write strobes are one-cycle pulses already qualified by the checks.
*/
`timescale 1ns/1ps
module cia_enable_store (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic phys_we,
  input wire logic virt_we,
  input wire logic wbit,
  output logic phys_en,
  output logic virt_en
);
  import cia_pkg::*;

  typedef struct packed {
    logic phys;
    logic virt;
  } cia_en_state_t;

  cia_en_state_t st_q;
  cia_en_state_t st_d;

  // only the enable bit is kept; upper written bits are dropped
  always_comb begin
    st_d = st_q;
    if (phys_we) begin
      st_d.phys = wbit;
    end
    if (virt_we) begin
      st_d.virt = wbit;
    end
  end

  // warm reset clears both enables
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{phys: CIA_EN_RESET, virt: CIA_EN_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign phys_en = st_q.phys;
  assign virt_en = st_q.virt;

endmodule : cia_enable_store

// ### verification/cia_props.sv
/*
  cia_props: port-level assertions for cia_top.
  assumes: bound to cia_top, one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cia_props import cia_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire cia_req_t req,
  input wire cia_ctl_t ctl,
  input wire logic [23:0] hppi_id,
  input wire cia_rsp_t rsp,
  input wire logic ack_pulse,
  input wire logic [23:0] ack_id,
  input wire logic retarget_pulse,
  input wire logic group0_enable,
  input wire logic virt_group0_enable,
  input wire logic virt_access
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // decode of the enable register and the group 1 acknowledge read
  wire logic grp_hit = req.valid && req.op0 == CIA_OP0 && req.op1 == CIA_OP1 &&
    req.crn == CIA_CRN && req.crm == CIA_CRM_GRP;
  wire logic en_hit = grp_hit && req.op2 == CIA_OP2_EN0;
  wire logic en_wr = en_hit && req.write;
  wire logic ack_hit = grp_hit && req.op2 == CIA_OP2_ACK1 && !req.write;
  wire logic top_ok = req.level == CIA_LVL3 && ctl.sre_lvl3;
  sequence s_top_ack;
    ack_hit && top_ok;
  endsequence
  sequence s_sync_wait;
    !rsp.done [*3] ##1 rsp.done;
  endsequence
  AST_UNMASKED_ACK: assert property (s_top_ack ##0 !ctl.core_masked |=>
    rsp.done && rsp.result == CIA_RES_DIRECT) else $error("ack read not answered");
  AST_MASKED_SYNC: assert property (s_top_ack ##0 ctl.core_masked |=> s_sync_wait)
    else $error("masked ack read timing wrong");
  AST_ACK_ID: assert property (ack_pulse |-> ack_id[15:0] == $past(hppi_id[15:0]))
    else $error("acknowledged id differs");
  AST_SPECIAL_SET: assert property (rsp.done && rsp.rdata[23:2] == 22'hff |->
    rsp.rdata[1:0] != 2'h2) else $error("special id 1022 returned");
  AST_HIGH_ZERO: assert property (rsp.done |-> rsp.rdata[63:24] == 40'h0 &&
    (ctl.id_wide || rsp.rdata[23:16] == 8'h0)) else $error("upper bits not zero");
  AST_EN_READ: assert property (en_hit && !req.write && top_ok |=> rsp.done &&
    rsp.rdata == {63'h0, group0_enable}) else $error("enable read wrong");
  AST_EN_WRITE: assert property (en_wr && top_ok |=>
    group0_enable == $past(req.wdata[0])) else $error("enable write wrong");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) !rstn |-> !group0_enable)
    else $error("enable set in reset");
  AST_LVL0_UNDEF: assert property ((en_hit || ack_hit) && req.level == CIA_LVL0 |=>
    rsp.done && rsp.result == CIA_RES_UNDEF) else $error("level zero not undefined");
  AST_SRE1_TRAP: assert property (en_hit && req.level == CIA_LVL1 && !ctl.sre_lvl1 &&
    !(ctl.lvl3_present && ctl.sdd_undef_priority && ctl.fiq_to_lvl3) |=>
    rsp.result == CIA_RES_TRAP && rsp.trap_level == CIA_LVL1 && rsp.ec == CIA_EC_SYSREG)
    else $error("interface-off trap wrong");
  AST_VIRT_WRITE: assert property (virt_access && $past(en_wr) |->
    virt_group0_enable == $past(req.wdata[0])) else $error("virtual enable wrong");
  AST_RETARGET: assert property (retarget_pulse |-> !group0_enable)
    else $error("retarget while enabled");
endmodule : cia_props

// ### verification/cia_hppi_model.sv
/*
  cia_hppi_model: pending-interrupt source standing in for the prioritiser.
  assumes: the bench loads each candidate; the block answers with pulses.
*/
`timescale 1ns/1ps
module cia_hppi_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [23:0] new_id,
  input wire logic new_grp0,
  input wire logic new_one_of_n,
  input wire logic ack_pulse,
  input wire logic retarget_pulse,
  output logic [23:0] hppi_id,
  output logic hppi_valid,
  output logic hppi_grp0,
  output logic hppi_one_of_n
);
  // a taken or moved interrupt leaves the slot; the id lines then show junk
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hppi_id <= 24'h0;
      hppi_valid <= 1'b0;
      hppi_grp0 <= 1'b0;
      hppi_one_of_n <= 1'b0;
    end else if (load) begin
      hppi_id <= new_id;
      hppi_valid <= 1'b1;
      hppi_grp0 <= new_grp0;
      hppi_one_of_n <= new_one_of_n;
    end else if (ack_pulse || retarget_pulse) begin
      hppi_valid <= 1'b0;
      hppi_id <= ~hppi_id;
    end
  end
endmodule : cia_hppi_model

// ### verification/cia_top_tb.sv
/*
  cia_top_tb: random and corner accesses to the enable and group 1 ack registers.
  assumes: cia_top, cia_props and cia_hppi_model compiled before this file.
*/
`timescale 1ns/1ps
module cia_top_tb;
  import cia_pkg::*;
  logic core_clk, rstn, load, n_grp0, n_1ofn, hv, hg, h1, hs, hsec, hak;
  logic ackp, rtp, g0e, vg0e, va, m_en, m_ven, s_done, s_ack, s_rt, s_va;
  logic [23:0] n_id, hid, aid;
  cia_req_t req;
  cia_ctl_t ctl, c;
  cia_rsp_t rsp;
  int mismatches, n_compared, cyc;
  cia_top dut (.core_clk(core_clk), .rstn(rstn), .req(req), .ctl(ctl), .hppi_id(hid),
    .hppi_valid(hv), .hppi_grp0(hg), .hppi_signalable(hs), .hppi_ackable(hak),
    .hppi_secure_only(hsec), .hppi_one_of_n(h1), .rsp(rsp), .ack_pulse(ackp), .ack_id(aid),
    .retarget_pulse(rtp), .group0_enable(g0e), .virt_group0_enable(vg0e), .virt_access(va));
  cia_hppi_model pm (.core_clk(core_clk), .rstn(rstn), .load(load), .new_id(n_id),
    .new_grp0(n_grp0), .new_one_of_n(n_1ofn), .ack_pulse(ackp), .retarget_pulse(rtp),
    .hppi_id(hid), .hppi_valid(hv), .hppi_grp0(hg), .hppi_one_of_n(h1));
  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // pulse catchers and a hang guard well above the planned run length
  always @(posedge core_clk) begin
    cyc++;
    if (rsp.done) s_done <= 1'b1;
    if (ackp) s_ack <= 1'b1;
    if (rtp) s_rt <= 1'b1;
    if (va) s_va <= 1'b1;
    if (cyc == 3000) begin
      mismatches++;
      $display("CHECK FAILED %0t timeout", $time);
      stop_test();
    end
  end
  task stop_test;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // expected outcome {result, level}; g picks the group 0 controls
  function automatic logic [4:0] exp_res(cia_ctl_t c, logic g, logic w, cia_lvl_t l);
    logic f, sp, fine;
    f = g ? c.fiq_to_lvl3 : c.irq_to_lvl3;
    sp = c.lvl3_present && c.sdd_undef_priority && f;
    fine = g && c.fine_trap_feature && (!c.lvl3_present || c.fine_trap_allow) &&
      (w ? c.fine_write_trap_grpen : c.fine_read_trap_grpen);
    if (l == CIA_LVL0 || (l != CIA_LVL3 && sp)) return {CIA_RES_UNDEF, l};
    if ((l == CIA_LVL1 && !c.sre_lvl1) || (l == CIA_LVL2 && !c.sre_lvl2) ||
      (l == CIA_LVL3 && !c.sre_lvl3)) return {CIA_RES_TRAP, l};
    if (l == CIA_LVL1 && c.lvl2_enabled) begin
      if (fine || (g ? c.trap_all_group0 : c.trap_all_group1)) return {CIA_RES_TRAP, CIA_LVL2};
      if (g ? c.fast_irq_route_to_hyp : c.irq_route_to_hyp) return {CIA_RES_VIRT, l};
    end
    if (l != CIA_LVL3 && c.lvl3_present && f)
      return {c.sdd_undef ? CIA_RES_UNDEF : CIA_RES_TRAP, CIA_LVL3};
    return {CIA_RES_DIRECT, l};
  endfunction : exp_res
  // one access held for one cycle, then a bounded wait for the answer
  task acc(input logic w, input logic [2:0] op2, input cia_lvl_t l, input logic [63:0] wd);
    int i;
    @(negedge core_clk);
    req = '{1'b1, w, CIA_OP0, CIA_OP1, CIA_CRN, CIA_CRM_GRP, op2, l, wd};
    {s_done, s_ack, s_rt, s_va} = 4'h0;
    @(negedge core_clk);
    req.valid = 1'b0;
    req.wdata = ~wd;
    for (i = 0; i < 6 && !s_done; i++) @(negedge core_clk);
    @(negedge core_clk);
  endtask : acc
  // k=1: enable register, k=0: group 1 acknowledge read
  task step(input logic k, input logic w, input cia_lvl_t l, input logic [63:0] wd,
    input logic [23:0] id, input logic g0, input logic on, input logic sg, input logic sc);
    logic [4:0] e;
    logic rt;
    logic dir;
    @(negedge core_clk);
    {ctl, n_id, n_grp0, n_1ofn, hs, hsec, load} = {c, id, g0, on, sg, sc, 1'b1};
    @(negedge core_clk);
    load = 1'b0;
    e = exp_res(c, k, w & k, l);
    dir = e[4:2] == CIA_RES_DIRECT;
    rt = 1'b0;
    acc(w & k, k ? CIA_OP2_EN0 : CIA_OP2_ACK1, l, wd);
    chk(s_done, 1'b1, "done");
    chk(rsp.result, e[4:2], "result");
    if (e[4:2] == CIA_RES_TRAP) chk({rsp.trap_level, rsp.ec}, {e[1:0], CIA_EC_SYSREG}, "trap");
    chk(s_va, e[4:2] == CIA_RES_VIRT, "virtual");
    if (k && dir && w) begin
      rt = m_en && !wd[0] && g0 && on;
      m_en = wd[0];
    end else if (k && dir) chk(rsp.rdata, {63'h0, m_en}, "enable read");
    if (k && w && e[4:2] == CIA_RES_VIRT) m_ven = wd[0];
    chk({g0e, vg0e, s_rt}, {m_en, m_ven, rt}, "enables");
    // a group 1 read takes only a group 1 interrupt that may be acknowledged here
    chk(s_ack, !k && dir && sg && !g0 && hak, "ack pulse");
    if (!k && dir) chk(rsp.rdata, !sg ? 64'h3ff : (!g0 && hak) ?
      {40'h0, c.id_wide ? id[23:16] : 8'h0, id[15:0]} : sc ? 64'h3fc : 64'h3ff, "ack id");
  endtask : step
  initial begin
    {req, ctl, c, load, n_id, n_grp0, n_1ofn, hs, hsec} = '0;
    {mismatches, n_compared, cyc, m_en, m_ven} = '0;
    hak = 1'b1;
    // reset falls after time zero so the asynchronous reset edge is never missed
    #1 rstn = 1'b0;
    void'($urandom(32'h21b84789));
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    chk(g0e, 1'b0, "reset enable");
    c.sre_lvl3 = 1'b1;
    step(1, 1, CIA_LVL3, 64'hffff_ffff_ffff_fffe, 24'h20, 1, 1, 1, 0);
    step(1, 1, CIA_LVL3, 64'h1, 24'h20, 1, 1, 1, 0);
    step(1, 1, CIA_LVL3, 64'h0, 24'h20, 1, 1, 1, 0);
    c.core_masked = 1'b1;
    step(0, 0, CIA_LVL3, 64'h0, 24'hab0123, 0, 0, 1, 0);
    acc(1'b0, 3'h7, CIA_LVL3, 64'h0);
    chk(s_done, 1'b0, "unmapped answered");
    repeat (70) begin
      c = cia_ctl_t'(19'($urandom & $urandom));
      {c.sre_lvl1, c.sre_lvl2, c.sre_lvl3} = {3{$urandom_range(0, 3) != 0}};
      {c.core_masked, c.id_wide} = 2'($urandom);
      hak = $urandom_range(0, 7) != 0;
      step(1'($urandom), 1'($urandom), cia_lvl_t'($urandom_range(0, 3)), {$urandom, $urandom},
        {8'($urandom), 16'($urandom_range(16, 1019))}, 1'($urandom), 1'($urandom),
        $urandom_range(0, 3) != 0, $urandom_range(0, 5) == 0);
    end
    stop_test();
  end
endmodule : cia_top_tb
bind cia_top cia_props u_props (.core_clk(core_clk), .rstn(rstn), .req(req), .ctl(ctl),
  .hppi_id(hppi_id), .rsp(rsp), .ack_pulse(ack_pulse), .ack_id(ack_id),
  .retarget_pulse(retarget_pulse), .group0_enable(group0_enable),
  .virt_group0_enable(virt_group0_enable), .virt_access(virt_access));
